// ---- stc_pin_model.sv ----
`timescale 1ns/100ps
module stc_pin_model (
  // Clock
  input wire logic i_clk,
  // Pin as driven by the timer
  input wire logic i_tp_out,
  input wire logic i_tp_oe,
  // Pin levels seen by the timer
  output logic o_ext_clk,
  output logic o_tp_in
);
  logic ext_lvl;
  initial begin
    o_ext_clk = 1'b0;
    ext_lvl = 1'b0;
  end
  // The shared pin reads back the timer's level while it drives
  assign o_tp_in = i_tp_oe ? i_tp_out : ext_lvl;
  // Six cycles per level so the three-stage synchroniser never misses one
  task automatic ext_edges(input int n);
    repeat (n) begin
      repeat (6) @(posedge i_clk);
      o_ext_clk <= 1'b1;
      repeat (6) @(posedge i_clk);
      o_ext_clk <= 1'b0;
    end
  endtask
  task automatic set_tp(input logic lvl);
    @(posedge i_clk);
    ext_lvl <= lvl;
  endtask
endmodule

// ---- stc_pkg.sv ----
package stc_pkg;
  // Register byte addresses on the APB bus
  localparam logic [7:0] STC_ADDR_RUN_CTRL = 8'h00;
  localparam logic [7:0] STC_ADDR_MODE_CTRL = 8'h04;
  localparam logic [7:0] STC_ADDR_COUNT_LOW = 8'h08;
  localparam logic [7:0] STC_ADDR_COUNT_HIGH = 8'h0C;
  localparam logic [7:0] STC_ADDR_CMPA_LOW = 8'h10;
  localparam logic [7:0] STC_ADDR_CMPA_HIGH = 8'h14;
  localparam logic [7:0] STC_ADDR_PERIOD = 8'h18;
  // Run and clock control fields
  localparam int STC_BIT_PAUSE = 7;
  localparam int STC_CKSEL_HI = 6;
  localparam int STC_CKSEL_LO = 4;
  localparam int STC_BIT_ENABLE = 3;
  localparam logic [7:0] STC_RUN_CTRL_MASK = 8'hF8;
  // Mode and pin control fields
  localparam int STC_MODE_HI = 7;
  localparam int STC_MODE_LO = 6;
  localparam int STC_PINF_HI = 5;
  localparam int STC_PINF_LO = 4;
  localparam int STC_BIT_OLC = 3;
  localparam int STC_BIT_INV = 2;
  localparam int STC_BIT_SWAP = 1;
  localparam int STC_BIT_CLRSEL = 0;
  localparam logic [7:0] STC_REG_RESET = 8'h00;
  localparam logic [15:0] STC_COUNT_ZERO = 16'h0000;
  localparam logic [16:0] STC_COUNT_ONE = 17'h0_0001;
  localparam logic [7:0] STC_LOW_ZERO = 8'h00;
  // Operating modes
  localparam logic [1:0] STC_MODE_CMP = 2'b00;
  localparam logic [1:0] STC_MODE_CAP = 2'b01;
  localparam logic [1:0] STC_MODE_PWM = 2'b10;
  localparam logic [1:0] STC_MODE_TMR = 2'b11;
  // Pin function codes
  localparam logic [1:0] STC_PF_00 = 2'b00;
  localparam logic [1:0] STC_PF_01 = 2'b01;
  localparam logic [1:0] STC_PF_10 = 2'b10;
  localparam logic [1:0] STC_PF_11 = 2'b11;
  // Clock source codes
  localparam logic [2:0] STC_CK_SYS4 = 3'b000;
  localparam logic [2:0] STC_CK_SYS = 3'b001;
  localparam logic [2:0] STC_CK_H16 = 3'b010;
  localparam logic [2:0] STC_CK_H64 = 3'b011;
  localparam logic [2:0] STC_CK_TBC = 3'b100;
  localparam logic [2:0] STC_CK_H8 = 3'b101;
  localparam logic [2:0] STC_CK_EXT_RISE = 3'b110;
  localparam logic [2:0] STC_CK_EXT_FALL = 3'b111;
  // Prescaler divide ratios
  localparam int STC_DIV_SYS = 4;
  localparam int STC_DIV_H8 = 8;
  localparam int STC_DIV_H16 = 16;
  localparam int STC_DIV_H64 = 64;
endpackage

// ---- stc_tick_gen.sv ----
`timescale 1ns/100ps
module stc_tick_gen
  import stc_pkg::*;
(
  // Clock and control
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [2:0] i_cksel,
  // Clock sources
  input wire logic i_tbc_tick,
  input wire logic i_ext_clk,
  // Count strobe
  output logic o_tick
);
  logic [5:0] pre;
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  wire ext_rise = ext_s2 & ~ext_s3;
  wire ext_fall = ~ext_s2 & ext_s3;
  wire tick_sys4 = (pre[1:0] == 2'(STC_DIV_SYS - 1));
  wire tick_h8 = (pre[2:0] == 3'(STC_DIV_H8 - 1));
  wire tick_h16 = (pre[3:0] == 4'(STC_DIV_H16 - 1));
  wire tick_h64 = (pre == 6'(STC_DIV_H64 - 1));
  logic sel_tick;

  // One free prescaler serves all internal divided rates
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pre <= '0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else if (i_ce) begin
      pre <= pre + 6'd1;
      ext_s1 <= i_ext_clk;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  always_comb begin
    case (i_cksel)
      STC_CK_SYS4: sel_tick = tick_sys4;
      STC_CK_SYS: sel_tick = 1'b1;
      STC_CK_H16: sel_tick = tick_h16;
      STC_CK_H64: sel_tick = tick_h64;
      STC_CK_TBC: sel_tick = i_tbc_tick;
      STC_CK_H8: sel_tick = tick_h8;
      STC_CK_EXT_RISE: sel_tick = ext_rise;
      default: sel_tick = ext_fall;
    endcase
  end

  assign o_tick = sel_tick & i_ce;
endmodule

// ---- stc_timer.sv ----
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module stc_timer
  import stc_pkg::*;
(
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Clock sources
  input wire logic I_TBC_TICK,
  input wire logic I_EXT_CLK,
  // Output and capture pin
  input wire logic I_TP_IN,
  output logic O_TP_OUT,
  output logic O_TP_OE,
  // Match requests
  output logic O_CMPA_MATCH,
  output logic O_CMPP_MATCH
);
  logic [7:0] run_ctrl;
  logic [7:0] mode_ctrl;
  logic [15:0] cmpa;
  logic [7:0] period;
  logic [15:0] cnt;
  logic en_prev;
  logic lvl;
  logic pulse_on;
  logic cap_s1;
  logic cap_s2;
  logic cap_s3;
  logic rd_err;
  logic tick;

  // Field views
  wire pause = run_ctrl[STC_BIT_PAUSE];
  wire [2:0] cksel = run_ctrl[STC_CKSEL_HI:STC_CKSEL_LO];
  wire enable = run_ctrl[STC_BIT_ENABLE];
  wire [1:0] mode = mode_ctrl[STC_MODE_HI:STC_MODE_LO];
  wire [1:0] pinf = mode_ctrl[STC_PINF_HI:STC_PINF_LO];
  wire olc = mode_ctrl[STC_BIT_OLC];
  wire inv = mode_ctrl[STC_BIT_INV];
  wire swap = mode_ctrl[STC_BIT_SWAP];
  wire clrsel = mode_ctrl[STC_BIT_CLRSEL];
  wire is_cmp = (mode == STC_MODE_CMP);
  wire is_cap = (mode == STC_MODE_CAP);
  wire is_pwm = (mode == STC_MODE_PWM);
  wire is_tmr = (mode == STC_MODE_TMR);

  // APB decode
  wire setup = I_PSEL & ~I_PENABLE;
  wire wr = I_PSEL & I_PENABLE & I_PWRITE;
  wire a_run = (I_PADDR == STC_ADDR_RUN_CTRL);
  wire a_mode = (I_PADDR == STC_ADDR_MODE_CTRL);
  wire a_cntl = (I_PADDR == STC_ADDR_COUNT_LOW);
  wire a_cnth = (I_PADDR == STC_ADDR_COUNT_HIGH);
  wire a_al = (I_PADDR == STC_ADDR_CMPA_LOW);
  wire a_ah = (I_PADDR == STC_ADDR_CMPA_HIGH);
  wire a_per = (I_PADDR == STC_ADDR_PERIOD);
  wire mapped = a_run | a_mode | a_cntl | a_cnth | a_al | a_ah | a_per;
  // Count bytes are read-only; writes to them are dropped
  wire wr_run = wr & a_run & I_CE;
  wire wr_mode = wr & a_mode & I_CE;
  wire wr_al = wr & a_al & I_CE;
  wire wr_ah = wr & a_ah & I_CE;
  wire wr_per = wr & a_per & I_CE;
  wire [7:0] rd_mux;
  assign rd_mux = a_run ? (run_ctrl & STC_RUN_CTRL_MASK) :
                  a_mode ? mode_ctrl :
                  a_cntl ? cnt[7:0] :
                  a_cnth ? cnt[15:8] :
                  a_al ? cmpa[7:0] :
                  a_ah ? cmpa[15:8] :
                  a_per ? period : STC_LOW_ZERO;

  // Counter step and comparators
  wire en_rise = enable & ~en_prev;
  wire run = enable & ~pause & ~en_rise;
  wire step = run & tick;
  wire [16:0] inc = {1'b0, cnt} + STC_COUNT_ONE;
  wire ovf = inc[16];
  wire a_hit = step & (inc[15:0] == cmpa);
  wire p_hit = step & (period != STC_LOW_ZERO)
               & (inc[15:0] == {period, STC_LOW_ZERO});
  wire p_wrap = step & ovf & (period == STC_LOW_ZERO);
  // PWM uses the swap bit; other modes use the clear select bit
  wire clr_by_a = is_pwm ? swap : clrsel;
  wire clr_now = clr_by_a ? (a_hit | (step & ovf)) : (p_hit | p_wrap | (step & ovf));
  wire [15:0] next_cnt = en_rise ? STC_COUNT_ZERO :
                         clr_now ? STC_COUNT_ZERO :
                         step ? inc[15:0] : cnt;
  wire flag_a = a_hit;
  wire flag_p = ~clr_by_a & (p_hit | p_wrap);

  // PWM duty compare against counter
  wire pwm_act_a = (cnt < cmpa);
  wire pwm_act_p = (period == STC_LOW_ZERO) | (cnt < {period, STC_LOW_ZERO});
  wire pwm_act = swap ? pwm_act_p : pwm_act_a;

  // Capture edges on the pin
  wire cap_rise = cap_s2 & ~cap_s3;
  wire cap_fall = ~cap_s2 & cap_s3;
  wire cap_hit = is_cap & enable & ((pinf == STC_PF_00 & cap_rise) |
                 (pinf == STC_PF_01 & cap_fall) |
                 (pinf == STC_PF_10 & (cap_rise | cap_fall)));

  // Compare-mode pin level on an A match
  logic cmp_lvl;
  always_comb begin
    case (pinf)
      STC_PF_01: cmp_lvl = 1'b0;
      STC_PF_10: cmp_lvl = 1'b1;
      STC_PF_11: cmp_lvl = ~lvl;
      default: cmp_lvl = lvl;
    endcase
  end

  // PWM and single pulse level, before polarity
  logic pwm_lvl;
  always_comb begin
    case (pinf)
      STC_PF_00: pwm_lvl = ~olc;
      STC_PF_01: pwm_lvl = olc;
      STC_PF_10: pwm_lvl = pwm_act ? olc : ~olc;
      default: pwm_lvl = pulse_on ? olc : ~olc;
    endcase
  end

  wire next_lvl = (is_cmp & en_rise) ? olc :
                  (is_cmp & a_hit) ? cmp_lvl :
                  is_pwm ? pwm_lvl : lvl;
  // Single pulse: starts on enable rise, ends on the A match
  wire next_pulse = en_rise ? 1'b1 : (a_hit ? 1'b0 : pulse_on);

  stc_tick_gen u_tick (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_cksel(cksel),
    .i_tbc_tick(I_TBC_TICK),
    .i_ext_clk(I_EXT_CLK),
    .o_tick(tick)
  );

  // Software registers
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      run_ctrl <= STC_REG_RESET;
      mode_ctrl <= STC_REG_RESET;
      period <= STC_REG_RESET;
    end else begin
      if (wr_run) run_ctrl <= I_PWDATA[7:0] & STC_RUN_CTRL_MASK;
      if (wr_mode) mode_ctrl <= I_PWDATA[7:0];
      if (wr_per) period <= I_PWDATA[7:0];
    end
  end

  // Compare A: software bytes, or counter snapshot on capture
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      cmpa <= STC_COUNT_ZERO;
    end else if (I_CE) begin
      if (cap_hit) cmpa <= cnt;
      else begin
        if (wr_al) cmpa[7:0] <= I_PWDATA[7:0];
        if (wr_ah) cmpa[15:8] <= I_PWDATA[7:0];
      end
    end
  end

  // Counter, pin level and match strobes
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      cnt <= STC_COUNT_ZERO;
      en_prev <= 1'b0;
      lvl <= 1'b0;
      pulse_on <= 1'b0;
      O_CMPA_MATCH <= 1'b0;
      O_CMPP_MATCH <= 1'b0;
    end else if (I_CE) begin
      cnt <= next_cnt;
      en_prev <= enable;
      lvl <= next_lvl;
      pulse_on <= next_pulse;
      O_CMPA_MATCH <= flag_a | cap_hit;
      O_CMPP_MATCH <= flag_p;
    end
  end

  // Capture pin synchroniser
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cap_s3 <= 1'b0;
    end else if (I_CE) begin
      cap_s1 <= I_TP_IN;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end

  // Read data is captured in the setup phase, so the access phase needs no wait
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_PRDATA <= '0;
      rd_err <= 1'b0;
    end else if (I_CE && setup) begin
      O_PRDATA <= {24'h00_0000, rd_mux};
      rd_err <= ~mapped;
    end
  end

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & rd_err;
  // The pin is driven in compare and PWM modes only
  assign O_TP_OE = (is_cmp | is_pwm) & ~I_SRST;
  assign O_TP_OUT = O_TP_OE & (lvl ^ inv);

  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);

  sequence s_en_rise;
    I_CE && en_rise;
  endsequence

  sequence s_held;
    I_CE && !enable;
  endsequence

  a_count_step: assert property (
    (I_CE && step && !clr_now) |=> (cnt == $past(cnt) + 16'd1))
    else $error("counter did not advance by one");

  a_enable_clear: assert property (
    s_en_rise |=> (cnt == STC_COUNT_ZERO) ##1 (cnt <= 16'd1))
    else $error("enable rise did not clear counter");

  a_off_holds: assert property (
    s_held |=> $stable(cnt))
    else $error("counter moved while disabled");

  a_pause_holds: assert property (
    (I_CE && pause && !en_rise) |=> (cnt == $past(cnt)))
    else $error("counter moved while paused");

  a_period_clear: assert property (
    (I_CE && !clr_by_a && p_hit) |=> (cnt == STC_COUNT_ZERO) && O_CMPP_MATCH)
    else $error("period match did not clear counter");

  a_cmpa_clear: assert property (
    (I_CE && clr_by_a && a_hit) |=> (cnt == STC_COUNT_ZERO) && O_CMPA_MATCH && !O_CMPP_MATCH)
    else $error("compare A match did not clear counter");

  a_init_level: assert property (
    (s_en_rise and is_cmp) |=> (lvl == $past(olc)))
    else $error("pin not set to initial level");

  a_toggle_pin: assert property (
    (I_CE && is_cmp && !en_rise && a_hit && pinf == STC_PF_11) |=> (lvl != $past(lvl)))
    else $error("toggle on compare A match missing");

  a_timer_float: assert property (
    is_tmr |-> !O_TP_OE && !O_TP_OUT)
    else $error("pin driven in timer mode");

  a_reserved_zero: assert property (
    (I_CE && setup && a_run) |=> (O_PRDATA[2:0] == 3'b000))
    else $error("reserved control bits read nonzero");

  sequence s_cmp_hit;
    I_CE && is_cmp && !en_rise && a_hit;
  endsequence

  a_match_low: assert property (
    (s_cmp_hit ##0 (pinf == STC_PF_01)) |=> !lvl)
    else $error("pin not driven low on compare A match");

  a_match_high: assert property (
    (s_cmp_hit ##0 (pinf == STC_PF_10)) |=> lvl)
    else $error("pin not driven high on compare A match");

  a_ce_freeze: assert property (
    !I_CE |=> $stable(cnt) && $stable(lvl) && $stable(run_ctrl))
    else $error("state moved while clock enable low");

  a_no_period_flag: assert property (
    (I_CE && clr_by_a) |=> !O_CMPP_MATCH)
    else $error("period request raised while compare A clears");

  a_capture_copy: assert property (
    (I_CE && cap_hit) |=> (cmpa == $past(cnt)) && O_CMPA_MATCH)
    else $error("capture did not copy the count");

  a_count_read: assert property (
    (I_CE && setup && a_cntl) |=> (O_PRDATA[7:0] == 8'($past(cnt))))
    else $error("count low byte read wrong");

  a_pwm_active: assert property (
    (I_CE && is_pwm && pinf == STC_PF_01) |=> (lvl == $past(olc)))
    else $error("forced active level missing");

  a_pwm_inactive: assert property (
    (I_CE && is_pwm && pinf == STC_PF_00) |=> (lvl != $past(olc)))
    else $error("forced inactive level missing");

  a_pwm_duty: assert property (
    (I_CE && is_pwm && !swap && pinf == STC_PF_10) |=> (lvl == ($past(pwm_act_a) ~^ $past(olc))))
    else $error("duty from compare A wrong");

  a_pwm_swap: assert property (
    (I_CE && is_pwm && swap && pinf == STC_PF_10) |=> (lvl == ($past(pwm_act_p) ~^ $past(olc))))
    else $error("duty from period compare wrong");
endmodule

// ---- stc_timer_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, a) begin \
  checks_done++; \
  if ((e) !== (a)) begin \
    num_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, a); \
  end \
end
module stc_timer_tb_top;
  import stc_pkg::*;
  localparam int TBC_GAP = 5;
  logic I_CLK = 1'b0;
  logic I_SRST = 1'b1;
  logic I_CE = 1'b1;
  logic I_PSEL = 1'b0;
  logic I_PENABLE = 1'b0;
  logic I_PWRITE = 1'b0;
  logic I_TBC_TICK = 1'b0;
  logic [7:0] I_PADDR = 8'h00;
  logic [31:0] I_PWDATA = 32'h0000_0000;
  logic [31:0] O_PRDATA;
  logic O_PREADY, O_PSLVERR, I_EXT_CLK, I_TP_IN, O_TP_OUT, O_TP_OE;
  logic O_CMPA_MATCH, O_CMPP_MATCH;
  logic [31:0] seed = 32'h07e7_2a45;
  logic [7:0] rd, v;
  logic [7:0] exp_q [$];
  logic err, ex;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int ac = 0;
  int pc = 0;
  int s, g, k;
  logic [2:0] sels [6] = '{STC_CK_SYS4, STC_CK_SYS, STC_CK_H16, STC_CK_H64, STC_CK_TBC, STC_CK_H8};
  int divs [6] = '{STC_DIV_SYS, 1, STC_DIV_H16, STC_DIV_H64, TBC_GAP, STC_DIV_H8};
  logic [7:0] pm [6] = '{8'hA8, 8'hA0, 8'hAA, 8'h88, 8'h98, 8'hAC};
  int ph [6] = '{2 * 64, 512 - 2 * 64, 512, 0, 512, 512 - 2 * 64};
  int ce [4] = '{1, 1, 2, 0};

  stc_timer stc_timer_i (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_CE(I_CE), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_TBC_TICK(I_TBC_TICK), .I_EXT_CLK(I_EXT_CLK), .I_TP_IN(I_TP_IN),
    .O_TP_OUT(O_TP_OUT), .O_TP_OE(O_TP_OE), .O_CMPA_MATCH(O_CMPA_MATCH),
    .O_CMPP_MATCH(O_CMPP_MATCH));
  stc_pin_model stc_pin_model_i (.i_clk(I_CLK), .i_tp_out(O_TP_OUT), .i_tp_oe(O_TP_OE),
    .o_ext_clk(I_EXT_CLK), .o_tp_in(I_TP_IN));

  initial begin
    forever #50 I_CLK = ~I_CLK;
  end

  // Match pulses are counted here so no single-cycle pulse is missed
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    I_TBC_TICK <= (cyc % TBC_GAP == 0);
    if (O_CMPA_MATCH === 1'b1) ac <= ac + 1;
    if (O_CMPP_MATCH === 1'b1) pc <= pc + 1;
    if (cyc == 60000) begin
      num_errors++;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= {24'h00_0000, d};
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    do @(posedge I_CLK); while (O_PREADY !== 1'b1);
    rd = O_PRDATA[7:0];
    err = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  // Timer is switched off around every mode or pin change
  task automatic cfg(input logic [7:0] m, input logic [7:0] r);
    apb(1'b1, STC_ADDR_RUN_CTRL, 8'h00);
    apb(1'b1, STC_ADDR_MODE_CTRL, m);
    apb(1'b1, STC_ADDR_RUN_CTRL, r);
  endtask

  task automatic seta(input logic [15:0] x);
    apb(1'b1, STC_ADDR_CMPA_LOW, x[7:0]);
    apb(1'b1, STC_ADDR_CMPA_HIGH, x[15:8]);
  endtask

  // Cycles between two match pulses; the first gap absorbs start-up
  task automatic gap(input logic p, output int n);
    int c;
    n = 0;
    c = p ? pc : ac;
    while ((p ? pc : ac) == c && n < 3000) begin
      @(posedge I_CLK);
      n++;
    end
    n = 0;
    c = p ? pc : ac;
    while ((p ? pc : ac) == c && n < 3000) begin
      @(posedge I_CLK);
      n++;
    end
  endtask

  initial begin
    repeat (12) @(posedge I_CLK);
    I_SRST <= 1'b0;
    for (int a = 0; a < 7; a++) begin
      apb(1'b0, 8'(a * 4), 8'h00);
      `CHK("reset value", 8'h00, rd)
    end
    apb(1'b1, STC_ADDR_RUN_CTRL, 8'hFF);
    apb(1'b0, STC_ADDR_RUN_CTRL, 8'h00);
    `CHK("run ctrl", STC_RUN_CTRL_MASK, rd)
    apb(1'b1, STC_ADDR_COUNT_LOW, 8'h55);
    apb(1'b0, STC_ADDR_COUNT_LOW, 8'h00);
    `CHK("count ro", 8'h00, rd)
    // All writes go first so a read that aliases another register shows up
    for (int a = 4; a < 7; a++) begin
      exp_q.push_back(8'(rnd()));
      apb(1'b1, 8'(a * 4), exp_q[$]);
    end
    for (int a = 4; a < 7; a++) begin
      apb(1'b0, 8'(a * 4), 8'h00);
      v = exp_q.pop_front();
      `CHK("readback", v, rd)
    end
    apb(1'b0, 8'h1C, 8'h00);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 8'h00, rd)
    $display("test registers end");
    for (int i = 0; i < 6; i++) begin
      k = 3 + int'(rnd() % 8);
      seta(16'(k));
      cfg(8'hC1, {1'b0, sels[i], 4'b1000});
      gap(1'b0, g);
      `CHK("interval", divs[i] * k, g)
      `CHK("timer oe", 1'b0, O_TP_OE)
    end
    apb(1'b1, STC_ADDR_PERIOD, 8'h01);
    cfg(8'hC0, 8'h18);
    gap(1'b1, g);
    `CHK("period", 256, g)
    $display("test clocks end");
    seta(16'h0003);
    for (int i = 6; i < 8; i++) begin
      cfg(8'hC1, {1'b0, 3'(i), 4'b1000});
      s = ac;
      stc_pin_model_i.ext_edges(6);
      repeat (8) @(posedge I_CLK);
      `CHK("ext matches", 2, ac - s)
    end
    $display("test external end");
    seta(16'hF000);
    cfg(8'hC1, 8'h18);
    repeat (30) @(posedge I_CLK);
    apb(1'b1, STC_ADDR_RUN_CTRL, 8'h98);
    apb(1'b0, STC_ADDR_COUNT_LOW, 8'h00);
    v = rd;
    repeat (20) @(posedge I_CLK);
    apb(1'b0, STC_ADDR_COUNT_LOW, 8'h00);
    `CHK("paused", v, rd)
    apb(1'b1, STC_ADDR_RUN_CTRL, 8'h18);
    apb(1'b0, STC_ADDR_COUNT_LOW, 8'h00);
    `CHK("resumed", 1'b1, rd > v)
    apb(1'b1, STC_ADDR_RUN_CTRL, 8'h10);
    apb(1'b0, STC_ADDR_COUNT_LOW, 8'h00);
    v = rd;
    repeat (20) @(posedge I_CLK);
    apb(1'b0, STC_ADDR_COUNT_LOW, 8'h00);
    `CHK("off holds", v, rd)
    apb(1'b1, STC_ADDR_RUN_CTRL, 8'h18);
    apb(1'b0, STC_ADDR_COUNT_LOW, 8'h00);
    `CHK("on clears", 1'b1, rd < v)
    // Two reads three edges apart differ by three, however long the enable is low between
    apb(1'b0, STC_ADDR_COUNT_LOW, 8'h00);
    v = rd;
    I_CE <= 1'b0;
    repeat (20) @(posedge I_CLK);
    I_CE <= 1'b1;
    apb(1'b0, STC_ADDR_COUNT_LOW, 8'h00);
    `CHK("ce freeze", 8'h03, rd - v)
    $display("test pause end");
    seta(16'h000A);
    for (int m = 0; m < 8; m++) begin
      cfg({2'b00, 2'(m >> 1), 1'(m), 3'b001}, 8'h18);
      repeat (3) @(posedge I_CLK);
      `CHK("pin initial", 1'(m), O_TP_OUT)
      `CHK("pin driven", 1'b1, O_TP_OE)
      ex = (m < 2) ? 1'(m) : (m < 4) ? 1'b0 : (m < 6) ? 1'b1 : ~1'(m);
      s = ac;
      for (k = 0; k < 40 && ac == s; k++) @(posedge I_CLK);
      repeat (2) @(posedge I_CLK);
      `CHK("pin on match", ex, O_TP_OUT)
    end
    $display("test compare end");
    apb(1'b1, STC_ADDR_PERIOD, 8'h01);
    seta(16'h0040);
    for (int i = 0; i < 6; i++) begin
      cfg(pm[i], 8'h18);
      repeat (20) @(posedge I_CLK);
      k = 0;
      repeat (512) begin
        @(posedge I_CLK);
        k += (O_TP_OUT === 1'b1);
      end
      `CHK("pwm high", ph[i], k)
    end
    $display("test pwm end");
    for (int i = 0; i < 4; i++) begin
      seta(16'hF000);
      cfg({2'b01, 2'(i), 4'b0000}, 8'h18);
      s = ac;
      stc_pin_model_i.set_tp(1'b1);
      repeat (10) @(posedge I_CLK);
      stc_pin_model_i.set_tp(1'b0);
      repeat (10) @(posedge I_CLK);
      `CHK("captures", ce[i], ac - s)
    end
    $display("test capture end");
    end_sim();
  end
endmodule
